// >>> design/bridge_window_pkg.sv
// Package with register map, field layout and request carrier for the memory window decode.
package bridge_window_pkg;

    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_MEM_WINDOW = 8'h20;
    localparam logic [7:0] OFS_PREFETCH_WINDOW = 8'h24;
    localparam logic [7:0] OFS_PREFETCH_BASE_HIGH = 8'h28;
    localparam logic [7:0] OFS_PREFETCH_LIMIT_HIGH = 8'h2C;

    localparam int BASE_LSB = 4;
    localparam int BASE_MSB = 15;
    localparam int LIMIT_LSB = 20;
    localparam int LIMIT_MSB = 31;
    localparam int PF_BASE_IND_LSB = 0;
    localparam int PF_LIMIT_IND_LSB = 16;
    localparam int WIN_FIELD_W = 12;
    localparam int WIN_LOW_W = 20;

    localparam logic [11:0] WIN_FIELD_RESET = 12'h000;
    localparam logic [31:0] HIGH_RESET = 32'h0000_0000;
    localparam logic [3:0] ADDR64_IND = 4'h1;
    localparam logic [19:0] WIN_LOW_BOTTOM = 20'h00000;
    localparam logic [19:0] WIN_LOW_TOP = 20'hFFFFF;

    typedef struct packed {
        logic valid;
        logic addr64;
        logic [63:0] addr;
    } mem_req_s;

    typedef struct packed {
        logic valid;
        logic hit_mem;
        logic hit_prefetch;
        logic forward;
    } mem_decode_s;

endpackage

// >>> design/window_compare.sv
// Range compare of one address against an expanded base and limit.
`timescale 1ns/1ps
module window_compare #(
    parameter int AW = 64
) (
    input wire logic [AW-1:0] i_addr,
    input wire logic [AW-1:0] i_bottom,
    input wire logic [AW-1:0] i_top,
    output logic o_hit
);
    // An inverted window (bottom above top) never matches since the two compares can never pass together.
    assign o_hit = (i_addr >= i_bottom) && (i_addr <= i_top);
endmodule

// >>> design/bridge_memory_window_decode.sv
// Memory and prefetchable window registers of a bridge port and the forward decode they drive.
//
// How it works
// - Memory base bits 15:4 are writable, give address 31:20, low bits zero, reset zero.
// - Memory limit bits 31:20 are writable, give address 31:20, low bits all ones.
// - Memory base and limit decide whether a memory request is forwarded.
// - Prefetch base bits 3:0 and limit bits 19:16 read 1h, showing 64-bit support.
// - Prefetch base bits 15:4 give bottom address 31:20; upper word gives 63:32.
// - Prefetch limit bits 31:20 give top address 31:20; upper word gives 63:32.
// - The 64-bit prefetch window decides whether memory reads and writes are forwarded.
// - Upper prefetch base at 28h is read-write, holds bottom 63:32, resets zero.
// - Upper prefetch limit at 2Ch is read-write, holds top 63:32, resets zero.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module bridge_memory_window_decode #(
    parameter int DATA_W = 32
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [bridge_window_pkg::ADDR_W-1:0] i_reg_addr,
    input wire logic [DATA_W-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [DATA_W-1:0] o_reg_rdata,
    input wire bridge_window_pkg::mem_req_s i_req,
    output bridge_window_pkg::mem_decode_s o_decode
);

    logic [11:0] mem_window_base;
    logic [11:0] mem_window_limit;
    logic [11:0] prefetch_window_base;
    logic [11:0] prefetch_window_limit;
    logic [31:0] prefetch_base_high;
    logic [31:0] prefetch_limit_high;
    logic [31:0] next_rdata;
    logic [63:0] mem_bottom;
    logic [63:0] mem_top;
    logic [63:0] pf_bottom;
    logic [63:0] pf_top;
    logic [63:0] req_addr;
    logic mem_hit;
    logic pf_hit;

    logic wr_mem;
    logic wr_pf;
    logic wr_bh;
    logic wr_lh;
    assign wr_mem = i_reg_wr && (i_reg_addr == bridge_window_pkg::OFS_MEM_WINDOW);
    assign wr_pf = i_reg_wr && (i_reg_addr == bridge_window_pkg::OFS_PREFETCH_WINDOW);
    assign wr_bh = i_reg_wr && (i_reg_addr == bridge_window_pkg::OFS_PREFETCH_BASE_HIGH);
    assign wr_lh = i_reg_wr && (i_reg_addr == bridge_window_pkg::OFS_PREFETCH_LIMIT_HIGH);

    // Only the writable fields are stored, so reserved and fixed bits cannot take a write.
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mem_window_base <= bridge_window_pkg::WIN_FIELD_RESET;
            mem_window_limit <= bridge_window_pkg::WIN_FIELD_RESET;
        end else if (wr_mem) begin
            mem_window_base <= i_reg_wdata[bridge_window_pkg::BASE_MSB:bridge_window_pkg::BASE_LSB];
            mem_window_limit <= i_reg_wdata[bridge_window_pkg::LIMIT_MSB:bridge_window_pkg::LIMIT_LSB];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            prefetch_window_base <= bridge_window_pkg::WIN_FIELD_RESET;
            prefetch_window_limit <= bridge_window_pkg::WIN_FIELD_RESET;
        end else if (wr_pf) begin
            prefetch_window_base <= i_reg_wdata[bridge_window_pkg::BASE_MSB:bridge_window_pkg::BASE_LSB];
            prefetch_window_limit <= i_reg_wdata[bridge_window_pkg::LIMIT_MSB:bridge_window_pkg::LIMIT_LSB];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            prefetch_base_high <= bridge_window_pkg::HIGH_RESET;
        end else if (wr_bh) begin
            prefetch_base_high <= i_reg_wdata[31:0];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            prefetch_limit_high <= bridge_window_pkg::HIGH_RESET;
        end else if (wr_lh) begin
            prefetch_limit_high <= i_reg_wdata[31:0];
        end
    end

    always_comb begin
        next_rdata = '0;
        case (i_reg_addr)
            bridge_window_pkg::OFS_MEM_WINDOW: begin
                next_rdata = {mem_window_limit, 4'h0, mem_window_base, 4'h0};
            end
            bridge_window_pkg::OFS_PREFETCH_WINDOW: begin
                next_rdata = {prefetch_window_limit, bridge_window_pkg::ADDR64_IND,
                              prefetch_window_base, bridge_window_pkg::ADDR64_IND};
            end
            bridge_window_pkg::OFS_PREFETCH_BASE_HIGH: begin
                next_rdata = prefetch_base_high;
            end
            bridge_window_pkg::OFS_PREFETCH_LIMIT_HIGH: begin
                next_rdata = prefetch_limit_high;
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe; otherwise the bus sees zero.
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_reg_rdata <= '0;
        end else if (i_reg_rd) begin
            o_reg_rdata <= next_rdata[DATA_W-1:0];
        end else begin
            o_reg_rdata <= '0;
        end
    end

    assign mem_bottom = {32'h0000_0000, mem_window_base, bridge_window_pkg::WIN_LOW_BOTTOM};
    assign mem_top = {32'h0000_0000, mem_window_limit, bridge_window_pkg::WIN_LOW_TOP};
    assign pf_bottom = {prefetch_base_high, prefetch_window_base,
                        bridge_window_pkg::WIN_LOW_BOTTOM};
    assign pf_top = {prefetch_limit_high, prefetch_window_limit,
                     bridge_window_pkg::WIN_LOW_TOP};
    // A 32-bit request carries zero in its upper word so it compares as a low 64-bit address.
    assign req_addr = i_req.addr64 ? i_req.addr : {32'h0000_0000, i_req.addr[31:0]};

    window_compare #(.AW(64)) u_mem_cmp (
        .i_addr(req_addr),
        .i_bottom(mem_bottom),
        .i_top(mem_top),
        .o_hit(mem_hit)
    );

    window_compare #(.AW(64)) u_pf_cmp (
        .i_addr(req_addr),
        .i_bottom(pf_bottom),
        .i_top(pf_top),
        .o_hit(pf_hit)
    );

    // Decode is registered so the answer stands one cycle after the request.
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_decode <= '0;
        end else begin
            o_decode.valid <= i_req.valid;
            o_decode.hit_mem <= i_req.valid && mem_hit;
            o_decode.hit_prefetch <= i_req.valid && pf_hit;
            o_decode.forward <= i_req.valid && (mem_hit || pf_hit);
        end
    end

    mem_reset_a: assert property (@(posedge i_sys_clk) $rose(i_nrst) |->
        o_reg_rdata == '0 && o_decode == '0)
        else $error("outputs not clear after reset");

    mem_rsvd_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_reg_rd && i_reg_addr == bridge_window_pkg::OFS_MEM_WINDOW |=>
        o_reg_rdata[3:0] == 4'h0 && o_reg_rdata[19:16] == 4'h0)
        else $error("memory window reserved bits not zero");

    pf_ind_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_reg_rd && i_reg_addr == bridge_window_pkg::OFS_PREFETCH_WINDOW |=>
        o_reg_rdata[3:0] == 4'h1 && o_reg_rdata[19:16] == 4'h1)
        else $error("prefetch indicator not 1h");

    mem_base_wr_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        wr_mem ##1 (i_reg_rd && i_reg_addr == bridge_window_pkg::OFS_MEM_WINDOW) |=>
        o_reg_rdata[15:4] == $past(i_reg_wdata[15:4], 2))
        else $error("memory base readback wrong");

    mem_limit_wr_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        wr_mem ##1 (i_reg_rd && i_reg_addr == bridge_window_pkg::OFS_MEM_WINDOW) |=>
        o_reg_rdata[31:20] == $past(i_reg_wdata[31:20], 2))
        else $error("memory limit readback wrong");

    base_high_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        wr_bh ##1 (i_reg_rd && i_reg_addr == bridge_window_pkg::OFS_PREFETCH_BASE_HIGH) |=>
        o_reg_rdata == $past(i_reg_wdata, 2))
        else $error("upper base readback wrong");

    limit_high_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        wr_lh ##1 (i_reg_rd && i_reg_addr == bridge_window_pkg::OFS_PREFETCH_LIMIT_HIGH) |=>
        o_reg_rdata == $past(i_reg_wdata, 2))
        else $error("upper limit readback wrong");

    mem_fwd_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_req.valid && !i_req.addr64 && i_req.addr[31:20] >= mem_window_base &&
        i_req.addr[31:20] <= mem_window_limit |=> o_decode.forward && o_decode.hit_mem)
        else $error("memory window hit not forwarded");

    pf_fwd_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_req.valid && i_req.addr64 &&
        i_req.addr[63:20] >= {prefetch_base_high, prefetch_window_base} &&
        i_req.addr[63:20] <= {prefetch_limit_high, prefetch_window_limit}
        |=> o_decode.hit_prefetch)
        else $error("prefetch window hit missed");

    empty_win_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        mem_window_base > mem_window_limit && !pf_hit |=> !o_decode.forward)
        else $error("inverted window claimed an address");

    // A stale read word left on the bus would be taken for a second answer by the master.
    rd_idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        !i_reg_rd |=> o_reg_rdata == '0)
        else $error("read data present without a read strobe");

    pf_base_wr_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        wr_pf ##1 (i_reg_rd && i_reg_addr == bridge_window_pkg::OFS_PREFETCH_WINDOW) |=>
        o_reg_rdata[15:4] == $past(i_reg_wdata[15:4], 2))
        else $error("prefetch base readback wrong");

    pf_limit_wr_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        wr_pf ##1 (i_reg_rd && i_reg_addr == bridge_window_pkg::OFS_PREFETCH_WINDOW) |=>
        o_reg_rdata[31:20] == $past(i_reg_wdata[31:20], 2))
        else $error("prefetch limit readback wrong");

    req_idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        !i_req.valid |=> o_decode == '0)
        else $error("decode active without a request");

endmodule

// >>> bench/mem_req_source.sv
// Request source model that presents memory requests to the window decode.
`timescale 1ns/1ps
module mem_req_source (
    input wire logic i_sys_clk,
    input wire logic i_go,
    input wire logic i_wide,
    input wire logic [63:0] i_addr,
    output bridge_window_pkg::mem_req_s o_req
);
    // Idle cycles carry an inverted address, so a stale address never looks like a live one.
    always_ff @(posedge i_sys_clk) begin
        o_req.valid <= i_go;
        o_req.addr64 <= i_wide;
        o_req.addr <= i_go ? i_addr : ~i_addr;
    end
endmodule

// >>> bench/bridge_memory_window_decode_tb.sv
// Self-checking testbench for the memory window registers and forward decode.
`timescale 1ns/1ps
module bridge_memory_window_decode_tb;
    logic i_sys_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] rdata;
    logic go = 1'b0;
    logic wide = 1'b0;
    logic [63:0] addr = 64'h0;
    bridge_window_pkg::mem_req_s req;
    bridge_window_pkg::mem_decode_s o_decode;
    int n_errors = 0;
    int checks_done = 0;

    initial begin
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end

    mem_req_source u_src (.i_sys_clk(i_sys_clk), .i_go(go), .i_wide(wide), .i_addr(addr),
        .o_req(req));

    bridge_memory_window_decode u_dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
        .i_reg_addr(reg_addr), .i_reg_wdata(wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
        .o_reg_rdata(rdata), .i_req(req), .o_decode(o_decode));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // The strobe is left up so that a following read or write comes with no gap.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        reg_addr <= a;
        wdata <= d;
        reg_rd <= 1'b0;
        reg_wr <= 1'b1;
    endtask

    // Read data stand only in the cycle after the strobe, so they are sampled just there.
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_sys_clk);
        reg_addr <= a;
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge i_sys_clk);
        reg_rd <= 1'b0;
        #1;
        check(64'(rdata), 64'(e));
    endtask

    // Expected nibble is valid, memory hit, prefetch hit, forward.
    task automatic probe(input logic v, input logic w, input logic [63:0] a,
        input logic [3:0] e);
        @(posedge i_sys_clk);
        reg_wr <= 1'b0;
        go <= v;
        wide <= w;
        addr <= a;
        @(posedge i_sys_clk);
        go <= 1'b0;
        @(posedge i_sys_clk);
        #1;
        check(64'(o_decode), 64'(e));
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #(100000 * 25);
        n_errors++;
        conclude();
    end

    initial begin
        repeat (5) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        rd(8'h20, 32'h0000_0000);
        rd(8'h24, 32'h0001_0001);
        rd(8'h28, 32'h0000_0000);
        rd(8'h2C, 32'h0000_0000);
        probe(1'b1, 1'b1, 64'h0, 4'hF);
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'hFFF0_FFF0);
        wr(8'h24, 32'hFFFF_FFFF);
        rd(8'h24, 32'hFFF1_FFF1);
        wr(8'h28, 32'hA5A5_5A5A);
        rd(8'h28, 32'hA5A5_5A5A);
        wr(8'h2C, 32'h5A5A_A5A5);
        rd(8'h2C, 32'h5A5A_A5A5);
        wr(8'h30, 32'h1234_5678);
        rd(8'h30, 32'h0000_0000);
        rd(8'h20, 32'hFFF0_FFF0);
        wr(8'h20, 32'h1240_1230);
        wr(8'h24, 32'h8000_8000);
        wr(8'h28, 32'h0000_0001);
        wr(8'h2C, 32'h0000_0001);
        rd(8'h24, 32'h8001_8001);
        probe(1'b1, 1'b0, 64'h1230_0000, 4'hD);
        probe(1'b1, 1'b0, 64'h122F_FFFF, 4'h8);
        probe(1'b1, 1'b0, 64'h124F_FFFF, 4'hD);
        probe(1'b1, 1'b0, 64'h1250_0000, 4'h8);
        probe(1'b1, 1'b0, 64'h1_1230_0000, 4'hD);
        probe(1'b1, 1'b1, 64'h1_1230_0000, 4'h8);
        probe(1'b1, 1'b1, 64'h1_8000_0000, 4'hB);
        probe(1'b1, 1'b1, 64'h1_800F_FFFF, 4'hB);
        probe(1'b1, 1'b1, 64'h1_7FFF_FFFF, 4'h8);
        probe(1'b1, 1'b1, 64'h1_8010_0000, 4'h8);
        probe(1'b1, 1'b1, 64'h0_8000_0000, 4'h8);
        probe(1'b0, 1'b1, 64'h1_8000_0000, 4'h0);
        wr(8'h20, 32'h1230_1240);
        probe(1'b1, 1'b0, 64'h1240_0000, 4'h8);
        probe(1'b1, 1'b0, 64'h1230_0000, 4'h8);
        conclude();
    end
endmodule
